// >>> dbl_top.sv
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - 8-bit read/write burst limit register
// - disabled: request held until FIFO full/empty
// - timeout: drop request at next FIFO access
// - timeout counting starts at first acknowledge
// - byte count: drop after programmed transfers
// - after drop, reassert only once acknowledge gone
// - write stores retained limit value
// - each request assertion reloads counting part
// - count per 3 clocks (120 ns) or per transfer
// - read returns counting part
// - independent of general timer
module dbl_top
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // axi4-lite write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // fifo state from the transfer engine
  input wire logic fifo_full,
  input wire logic fifo_empty,
  // dma pins
  input wire logic dack_n,
  output logic drq
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  dbl_pkg::dbl_ctrl_t ctrl_q;
  logic [7:0] mem_q;
  logic [7:0] cnt_q;
  logic [1:0] dack_sync_q;
  logic [1:0] full_sync_q;
  logic [1:0] empty_sync_q;
  logic dack_q;
  logic counting_q;
  logic expired_q;
  logic [1:0] tick_q;
  logic [7:0] aw_q;
  logic aw_have_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic w_have_q;
  logic dack_now;
  logic dack_rise;
  logic stop_cond;
  logic raise_req;
  logic tick;
  logic wr_fire;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_REQ = 3'b010,
    ST_HOLD = 3'b100
  } dbl_state_t;
  dbl_state_t st_q;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  // two stages before any logic sees the pins
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dack_sync_q <= 2'b11;
      full_sync_q <= 2'b00;
      empty_sync_q <= 2'b00;
      dack_q <= 1'b0;
    end
    else
    begin
      dack_sync_q <= {dack_sync_q[0], dack_n};
      full_sync_q <= {full_sync_q[0], fifo_full};
      empty_sync_q <= {empty_sync_q[0], fifo_empty};
      dack_q <= dack_now;
    end
  end

  assign dack_now = ~dack_sync_q[1];
  assign dack_rise = dack_now & ~dack_q;

  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------
  assign wr_fire = aw_have_q & w_have_q & ~bvalid;

  // write channels are taken in either order
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= dbl_pkg::RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_q <= awaddr;
        aw_have_q <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_q <= wdata;
        ws_q <= wstrb;
        w_have_q <= 1'b1;
        wready <= 1'b0;
      end
      if (wr_fire)
      begin
        bvalid <= 1'b1;
        bresp <= (aw_q == dbl_pkg::ADDR_LIMIT ||
                  aw_q == dbl_pkg::ADDR_CTRL ||
                  aw_q == dbl_pkg::ADDR_STAT) ?
                 dbl_pkg::RESP_OKAY : dbl_pkg::RESP_SLVERR;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // retained limit and control written from the bus
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mem_q <= dbl_pkg::LIMIT_RESET;
      ctrl_q <= '0;
    end
    else if (wr_fire && ws_q[0])
    begin
      if (aw_q == dbl_pkg::ADDR_LIMIT)
        mem_q <= w_q[7:0];
      if (aw_q == dbl_pkg::ADDR_CTRL)
        ctrl_q <= dbl_pkg::dbl_ctrl_t'(w_q[3:0]);
    end
  end

  // read channel, one cycle answer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= dbl_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= dbl_pkg::RESP_OKAY;
      unique case (araddr)
        dbl_pkg::ADDR_LIMIT: rdata <= {24'h00_0000, cnt_q};
        dbl_pkg::ADDR_CTRL: rdata <= {28'h000_0000, ctrl_q};
        dbl_pkg::ADDR_STAT: rdata <= {29'h0000_0000, expired_q,
                                      counting_q, drq};
        default:
        begin
          rdata <= 32'h0000_0000;
          rresp <= dbl_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // request state machine
  // ------------------------------------------------------------
  // own counter only, no link to any other timer
  assign stop_cond = ctrl_q.dir_read ? empty_sync_q[1] : full_sync_q[1];
  assign raise_req = (st_q == ST_IDLE) && ctrl_q.go && !stop_cond;
  assign tick = (tick_q == dbl_pkg::TICK_LAST);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= ST_IDLE;
      drq <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE:
          if (raise_req)
          begin
            st_q <= ST_REQ;
            drq <= 1'b1;
          end
        ST_REQ:
          // fifo limit always ends the burst
          if (stop_cond)
          begin
            st_q <= ST_IDLE;
            drq <= 1'b0;
          end
          else if (ctrl_q.burst_limit_enable && dack_rise && (expired_q ||
                   (!ctrl_q.time_not_count_select && cnt_q == 8'hFF)))
          begin
            st_q <= ST_HOLD;
            drq <= 1'b0;
          end
        ST_HOLD:
          if (!dack_now)
            st_q <= ST_IDLE;
        default:
        begin
          st_q <= ST_IDLE;
          drq <= 1'b0;
        end
      endcase
    end
  end
  // ------------------------------------------------------------
  // counting part
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q <= dbl_pkg::LIMIT_RESET;
      counting_q <= 1'b0;
      expired_q <= 1'b0;
      tick_q <= 2'b00;
    end
    else if (raise_req)
    begin
      cnt_q <= mem_q;
      counting_q <= 1'b0;
      expired_q <= 1'b0;
      tick_q <= 2'b00;
    end
    else if (st_q == ST_REQ)
    begin
      if (ctrl_q.time_not_count_select)
      begin
        if (dack_rise)
          counting_q <= 1'b1;
        if (counting_q && !expired_q)
        begin
          tick_q <= tick ? 2'b00 : tick_q + 2'b01;
          if (tick)
          begin
            cnt_q <= cnt_q + 8'h01;
            expired_q <= (cnt_q == 8'hFF);
          end
        end
      end
      else if (dack_rise && !expired_q)
      begin
        cnt_q <= cnt_q + 8'h01;
        expired_q <= (cnt_q == 8'hFF);
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence reload_s;
    raise_req;
  endsequence
  reload_cnt_a: assert property (@(posedge clk) disable iff (!nrst)
    reload_s |=> cnt_q == $past(mem_q))
    else $error("count not reloaded");
  rd_cnt_a: assert property (@(posedge clk) disable iff (!nrst)
    (arvalid && arready && araddr == dbl_pkg::ADDR_LIMIT)
    |=> rdata[7:0] == $past(cnt_q))
    else $error("limit read wrong");
  hold_dack_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_q == ST_HOLD) |-> !drq)
    else $error("request during hold");
  dis_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_q == ST_REQ && !ctrl_q.burst_limit_enable && !stop_cond)
    |=> drq)
    else $error("request dropped early");
  wrap_exp_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(expired_q) |-> cnt_q == 8'h00)
    else $error("expiry without wrap");
  start_cnt_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_q == ST_REQ && !counting_q && ctrl_q.time_not_count_select)
    |=> $stable(cnt_q) || $past(raise_req))
    else $error("counted before ack");
  drop_req_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_q == ST_REQ && ctrl_q.burst_limit_enable && expired_q
     && dack_rise && !stop_cond) |=> !drq)
    else $error("request not dropped");
  mem_wr_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_fire && ws_q[0] && aw_q == dbl_pkg::ADDR_LIMIT)
    |=> mem_q == $past(w_q[7:0]))
    else $error("limit not stored");
endmodule : dbl_top
`default_nettype wire

// >>> dbl_pkg.sv
package dbl_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_LIMIT = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_TIME_BIT = 1;
  localparam int CTRL_DIR_BIT = 2;
  localparam int CTRL_GO_BIT = 3;
  localparam logic [7:0] LIMIT_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int TICK_NS = 100;
  localparam int CLK_NS = 40;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] TICK_LAST = 2'(TICK_CYC - 1);

  // control fields gathered together
  typedef struct packed {
    logic go;
    logic dir_read;
    logic time_not_count_select;
    logic burst_limit_enable;
  } dbl_ctrl_t;

endpackage : dbl_pkg

// >>> dbl_dmac_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far-side dma controller model
// ----------------------------------------
module dbl_dmac_model
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // request and acknowledge
  input wire logic drq,
  input wire logic [3:0] gap,
  output logic dack_n,
  // transfers started so far
  output logic [7:0] xfers
);
  logic [4:0] cnt_q;

  // four cycles of acknowledge, then idle for gap plus four cycles
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dack_n <= 1'b1;
      cnt_q <= 5'h00;
      xfers <= 8'h00;
    end
    else if (!dack_n)
    begin
      if (cnt_q == 5'h00)
      begin
        dack_n <= 1'b1;
        cnt_q <= 5'(gap) + 5'h03;
      end
      else
        cnt_q <= cnt_q - 5'h01;
    end
    else if (!drq)
      cnt_q <= 5'(gap) + 5'h03;
    else if (cnt_q != 5'h00)
      cnt_q <= cnt_q - 5'h01;
    else
    begin
      dack_n <= 1'b0;  // a cycle starts only while request is up
      cnt_q <= 5'h03;
      xfers <= xfers + 8'h01;
    end
  end
endmodule : dbl_dmac_model
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    dbl_pkg::dbl_ctrl_t c;
    logic [7:0] lim;
    logic [3:0] gp;
    logic [7:0] lo;
    logic [7:0] hi;
  } dbl_row_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic fifo_full = 1'b0, fifo_empty = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, drq, dack_n;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [3:0] gap = 4'h0;
  logic [7:0] xfers;
  int num_errors = 0;
  int checks = 0;
  int cy, nx, v;
  // byte rows count transfers, timeout rows count cycles
  localparam dbl_row_t ROWS [5] = '{
    '{4'h9, 8'hFF, 4'h0, 8'h01, 8'h01},
    '{4'h9, 8'hFD, 4'h6, 8'h03, 8'h03},
    '{4'h9, 8'hFC, 4'h2, 8'h04, 8'h04},
    '{4'hB, 8'hF8, 4'h0, 8'h1C, 8'h30},
    '{4'hB, 8'hFC, 4'hC, 8'h1C, 8'h3C}};

  always #20 clk = ~clk;

  dbl_top u_dut (.clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .fifo_full, .fifo_empty,
    .dack_n, .drq);
  dbl_dmac_model u_dmac (.clk, .nrst, .drq, .gap, .dack_n, .xfers);

  task automatic err(input string m);
    num_errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask : err

  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1)
      err(m);
  endtask : chk

  // write address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] x,
                     output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      n++;
    end
    while (!bvalid && n < 40);
    if (!bvalid)
    begin
      err("write hung");
      print_verdict();
    end
    rs = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] x,
                     output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
      n++;
    end
    while (!rvalid && n < 40);
    if (!rvalid)
    begin
      err("read hung");
      print_verdict();
    end
    x = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axr

  task automatic wait_drq(input logic lv, input int lim, output int c);
    c = 0;
    while (drq !== lv)
    begin
      @(posedge clk);
      c++;
      if (c > lim)
      begin
        err("drq wait");
        print_verdict();
      end
    end
  endtask : wait_drq

  // cycles and transfers from request rise to request fall
  task automatic burst(output int c, output int t);
    logic [7:0] x0;
    wait_drq(1'b1, 100, c);
    x0 = xfers;
    wait_drq(1'b0, 300, c);
    t = int'(xfers - x0);
  endtask : burst

  // a fresh request must never meet a held acknowledge
  logic drq_d = 1'b0;
  always @(posedge clk)
  begin
    if (drq && !drq_d)
      chk(dack_n === 1'b1, "drq rose during dack");
    drq_d <= drq;
  end

  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    // table of limited bursts, each burst run twice
    foreach (ROWS[i])
    begin
      gap <= ROWS[i].gp;
      axw(dbl_pkg::ADDR_LIMIT, {24'h00_0000, ROWS[i].lim}, r);
      axw(dbl_pkg::ADDR_CTRL, {28'h000_0000, ROWS[i].c}, r);
      repeat (2)
      begin
        burst(cy, nx);
        v = ROWS[i].c.time_not_count_select ? cy : nx;
        chk(v >= ROWS[i].lo && v <= ROWS[i].hi, "burst len");
      end
      fifo_full <= 1'b1;
      wait_drq(1'b0, 40, cy);
      axw(dbl_pkg::ADDR_CTRL, 32'h0000_0000, r);
      fifo_full <= 1'b0;
    end
    // reset in mid-run, then the counting part on read
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(drq === 1'b0, "drq in reset");
    nrst <= 1'b1;
    axr(dbl_pkg::ADDR_LIMIT, d, r);
    chk(d === 32'h0000_0000, "limit reset");
    axw(dbl_pkg::ADDR_LIMIT, 32'h0000_005A, r);
    chk(r === dbl_pkg::RESP_OKAY, "limit write");
    axr(dbl_pkg::ADDR_LIMIT, d, r);
    chk(d === 32'h0000_0000, "read shows counter");
    // unmapped place
    axr(8'h0C, d, r);
    chk(r === dbl_pkg::RESP_SLVERR && d === 32'h0, "bad read");
    axw(8'h0C, 32'h0000_00FF, r);
    chk(r === dbl_pkg::RESP_SLVERR, "bad write");
    // limit disabled: only the fifo state stops the request
    fifo_empty <= 1'b1;
    axw(dbl_pkg::ADDR_CTRL, 32'h0000_0008, r);
    wait_drq(1'b1, 20, cy);
    repeat (120) @(posedge clk);
    chk(drq === 1'b1, "drq held");
    axr(dbl_pkg::ADDR_STAT, d, r);
    chk(d === 32'h0000_0001, "status shows request");
    axr(dbl_pkg::ADDR_CTRL, d, r);
    chk(d === 32'h0000_0008, "control read back");
    fifo_full <= 1'b1;
    wait_drq(1'b0, 8, cy);
    axw(dbl_pkg::ADDR_CTRL, 32'h0000_000C, r);
    repeat (8) @(posedge clk);
    chk(drq === 1'b0, "empty keeps drq low");
    fifo_empty <= 1'b0;
    wait_drq(1'b1, 8, cy);
    fifo_empty <= 1'b1;
    wait_drq(1'b0, 8, cy);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
